// ===== rtl/rvt_pkg.sv
// constants, field layouts and carrier types of the ring validation timer
// assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus
package rvt_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam real         CLK_MHZ          = 125.0;
  localparam real         TICK_MS          = 2.0;
  localparam int unsigned TICK_CYCLES      = int'(TICK_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned DELAY_STEP_MS    = 256;
  localparam int unsigned DELAY_STEP_TICKS = int'(real'(DELAY_STEP_MS) / TICK_MS);

  // ***********************************************************
  // register map: printed offsets are indices, byte address is 4x
  // ***********************************************************
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned REG_CTRL1_IDX   = 'h16;
  localparam int unsigned REG_CTRL2_IDX   = 'h17;
  localparam int unsigned REG_CTRL3_IDX   = 'h18;
  localparam int unsigned REG_STATUS_IDX  = 'h19;
  localparam logic [7:0]  CTRL1_RESET     = 8'h96;
  localparam logic [7:0]  CTRL2_RESET     = 8'h00;
  localparam logic [7:0]  CTRL3_RESET     = 8'h19;

  // field positions
  localparam int unsigned DLY_LO_POS      = 6;
  localparam int unsigned DLY_HI_POS      = 7;
  localparam int unsigned ENABLE_POS      = 7;
  localparam int unsigned STAT_VALID_POS  = 0;
  localparam int unsigned STAT_FERR_POS   = 1;
  localparam int unsigned STAT_TIMER_POS  = 8;
  localparam int unsigned CNT_W           = 6;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  typedef enum {SEL_CTRL1, SEL_CTRL2, SEL_CTRL3, SEL_STATUS, SEL_NONE} rvt_sel_e;
  typedef enum {ST_IDLE, ST_WAIT, ST_VALID, ST_BAD} rvt_state_e;

  // configuration as software leaves it
  typedef struct packed {
    logic             ring_validation_enable;
    logic [2:0]       valid_ring_delay_code;
    logic [CNT_W-1:0] ring_start_count;
    logic [CNT_W-1:0] ring_max_count;
  } rvt_cfg_s;

  // state shown back to software
  typedef struct packed {
    logic             valid;
    logic             freq_err;
    logic [CNT_W-1:0] timer;
  } rvt_stat_s;

endpackage : rvt_pkg

// ===== rtl/rvt_tick.sv
// free-running prescaler giving one pulse per qualification step
// assumes CYCLES is the number of system clocks in one step
`timescale 1ns/1ps
module rvt_tick #(
  parameter int unsigned CYCLES = rvt_pkg::TICK_CYCLES
) (
  input  wire logic CLK_SYS,
  input  wire logic NRST,
  output logic      tick
);

  localparam int unsigned W = $clog2(CYCLES);

  if (CYCLES < 2) begin : g_chk
    $error("rvt_tick: CYCLES must be at least 2");
  end

  logic [W-1:0] cnt_r;

  // count down, pulse and reload at zero
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r <= W'(CYCLES - 1);
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule : rvt_tick

// ===== rtl/rvt_qual_timer.sv
// ring frequency qualification timer: load on event, step down per tick
// assumes load and tick are one-cycle pulses in the system clock domain
`timescale 1ns/1ps
module rvt_qual_timer #(
  parameter int unsigned W = rvt_pkg::CNT_W
) (
  input  wire logic         CLK_SYS,
  input  wire logic         NRST,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  output logic      [W-1:0] count
);

  // load beats tick; stick at zero so slow rings always pass
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (tick && count != '0) begin
      count <= count - 1'b1;
    end
  end

endmodule : rvt_qual_timer

// ===== rtl/rvt_top.sv
// ring validation timer: delay before valid ring and frequency qualifier
// assumes RING_DET is a level and TR_EVENT a one-cycle pulse, both
// synchronous to CLK_SYS, and an AXI4-Lite master with one access at a time
`timescale 1ns/1ps
module rvt_top #(
  parameter int unsigned TICK_CYCLES = rvt_pkg::TICK_CYCLES,
  parameter int unsigned STEP_TICKS  = rvt_pkg::DELAY_STEP_TICKS
) (
  input  wire logic                       CLK_SYS,
  input  wire logic                       NRST,
  // ring detector front end
  input  wire logic                       RING_DET,
  input  wire logic                       TR_EVENT,
  output logic                            RING_VALID,
  output logic                            RING_INVALID,
  // AXI4-Lite slave
  input  wire logic [rvt_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                       S_AXI_AWVALID,
  output logic                            S_AXI_AWREADY,
  input  wire logic [31:0]                S_AXI_WDATA,
  input  wire logic [3:0]                 S_AXI_WSTRB,
  input  wire logic                       S_AXI_WVALID,
  output logic                            S_AXI_WREADY,
  output logic [1:0]                      S_AXI_BRESP,
  output logic                            S_AXI_BVALID,
  input  wire logic                       S_AXI_BREADY,
  input  wire logic [rvt_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                       S_AXI_ARVALID,
  output logic                            S_AXI_ARREADY,
  output logic [31:0]                     S_AXI_RDATA,
  output logic [1:0]                      S_AXI_RRESP,
  output logic                            S_AXI_RVALID,
  input  wire logic                       S_AXI_RREADY
);

  localparam int unsigned CW = rvt_pkg::CNT_W;

  if (STEP_TICKS < 1 || STEP_TICKS > 4096) begin : g_chk
    $error("rvt_top: STEP_TICKS out of range");
  end

  // ***********************************************************
  // address decode
  // ***********************************************************
  function automatic rvt_pkg::rvt_sel_e reg_sel(input logic [rvt_pkg::ADDR_W-1:0] a);
    logic [rvt_pkg::ADDR_W-1:0] base;
    base = '0;
    reg_sel = rvt_pkg::SEL_NONE;
    if (a[1:0] == 2'h0) begin
      base = a >> 2;
      case (base)
        rvt_pkg::ADDR_W'(rvt_pkg::REG_CTRL1_IDX):  reg_sel = rvt_pkg::SEL_CTRL1;
        rvt_pkg::ADDR_W'(rvt_pkg::REG_CTRL2_IDX):  reg_sel = rvt_pkg::SEL_CTRL2;
        rvt_pkg::ADDR_W'(rvt_pkg::REG_CTRL3_IDX):  reg_sel = rvt_pkg::SEL_CTRL3;
        rvt_pkg::ADDR_W'(rvt_pkg::REG_STATUS_IDX): reg_sel = rvt_pkg::SEL_STATUS;
        default:                                   reg_sel = rvt_pkg::SEL_NONE;
      endcase
    end
  endfunction : reg_sel

  // ***********************************************************
  // register state
  // ***********************************************************
  logic [7:0]         ctrl1_r;
  logic [7:0]         ctrl2_r;
  logic [7:0]         ctrl3_r;
  logic               ferr_r;
  rvt_pkg::rvt_cfg_s  cfg;
  rvt_pkg::rvt_stat_s stat;

  // write channel holding
  logic                       aw_got_r;
  logic                       w_got_r;
  logic [rvt_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0]                wdata_r;
  logic                       wstrb0_r;
  logic                       wr_fire;
  rvt_pkg::rvt_sel_e          wsel;

  assign S_AXI_AWREADY = !aw_got_r && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_got_r && !S_AXI_BVALID;
  assign wr_fire       = aw_got_r && w_got_r;
  assign wsel          = reg_sel(awaddr_r);

  // address and data are taken in either order, held until both are in
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb0_r <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r  <= 1'b1;
        wdata_r  <= S_AXI_WDATA;
        wstrb0_r <= S_AXI_WSTRB[0];
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= rvt_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= (wsel == rvt_pkg::SEL_NONE) ? rvt_pkg::RESP_DECERR
                                                  : rvt_pkg::RESP_OKAY;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // control registers; only the low byte lane carries data
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ctrl1_r <= rvt_pkg::CTRL1_RESET;
      ctrl2_r <= rvt_pkg::CTRL2_RESET;
      ctrl3_r <= rvt_pkg::CTRL3_RESET;
    end else if (wr_fire && wstrb0_r) begin
      case (wsel)
        rvt_pkg::SEL_CTRL1: ctrl1_r <= wdata_r[7:0];
        rvt_pkg::SEL_CTRL2: ctrl2_r <= {wdata_r[rvt_pkg::DLY_HI_POS], 7'h00};
        rvt_pkg::SEL_CTRL3: ctrl3_r <= {wdata_r[rvt_pkg::ENABLE_POS], 1'b0,
                                        wdata_r[CW-1:0]};
        default:            ctrl1_r <= ctrl1_r;
      endcase
    end
  end

  // fields gathered for the qualifier
  assign cfg.ring_validation_enable = ctrl3_r[rvt_pkg::ENABLE_POS];
  assign cfg.valid_ring_delay_code  = {ctrl2_r[rvt_pkg::DLY_HI_POS],
                                       ctrl1_r[rvt_pkg::DLY_HI_POS:rvt_pkg::DLY_LO_POS]};
  assign cfg.ring_start_count       = ctrl3_r[CW-1:0];
  assign cfg.ring_max_count         = ctrl1_r[CW-1:0];

  // ***********************************************************
  // read channel
  // ***********************************************************
  logic [31:0] rd_word;

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // read word for every register; reserved bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_sel(S_AXI_ARADDR))
      rvt_pkg::SEL_CTRL1:  rd_word[7:0] = ctrl1_r;
      rvt_pkg::SEL_CTRL2:  rd_word[7:0] = ctrl2_r;
      rvt_pkg::SEL_CTRL3:  rd_word[7:0] = ctrl3_r;
      rvt_pkg::SEL_STATUS: begin
        rd_word[rvt_pkg::STAT_VALID_POS] = stat.valid;
        rd_word[rvt_pkg::STAT_FERR_POS]  = stat.freq_err;
        rd_word[rvt_pkg::STAT_TIMER_POS +: CW] = stat.timer;
      end
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= rvt_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= (reg_sel(S_AXI_ARADDR) == rvt_pkg::SEL_NONE)
                      ? rvt_pkg::RESP_DECERR : rvt_pkg::RESP_OKAY;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ***********************************************************
  // qualification datapath
  // ***********************************************************
  localparam int unsigned DW = $clog2(8 * STEP_TICKS + 1);

  rvt_pkg::rvt_state_e state_r;
  logic                tick;
  logic                seen_r;
  logic [CW-1:0]       timer;
  logic                tm_load;
  logic                too_fast;
  logic [DW-1:0]       dly_cnt_r;
  logic [DW-1:0]       dly_goal;
  logic                active;

  rvt_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .CLK_SYS (CLK_SYS),
    .NRST    (NRST),
    .tick    (tick)
  );

  rvt_qual_timer #(
    .W (CW)
  ) u_timer (
    .CLK_SYS  (CLK_SYS),
    .NRST     (NRST),
    .load     (tm_load),
    .load_val (cfg.ring_start_count),
    .tick     (tick),
    .count    (timer)
  );

  assign active   = (state_r == rvt_pkg::ST_WAIT) || (state_r == rvt_pkg::ST_VALID);
  // spacing shorter than start minus max leaves the timer above max
  assign too_fast = seen_r && (timer > cfg.ring_max_count);
  assign tm_load  = active && TR_EVENT && !too_fast;
  assign dly_goal = DW'(cfg.valid_ring_delay_code) * DW'(STEP_TICKS);

  // ring sequencing; disabling validation drops back to idle at once
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_r <= rvt_pkg::ST_IDLE;
    end else if (!cfg.ring_validation_enable || !RING_DET) begin
      state_r <= rvt_pkg::ST_IDLE;
    end else begin
      case (state_r)
        rvt_pkg::ST_IDLE:  state_r <= rvt_pkg::ST_WAIT;
        rvt_pkg::ST_WAIT: begin
          if (TR_EVENT && too_fast) begin
            state_r <= rvt_pkg::ST_BAD;
          end else if (dly_cnt_r >= dly_goal) begin
            state_r <= rvt_pkg::ST_VALID;
          end
        end
        rvt_pkg::ST_VALID: begin
          if (TR_EVENT && too_fast) begin
            state_r <= rvt_pkg::ST_BAD;
          end
        end
        rvt_pkg::ST_BAD:   state_r <= rvt_pkg::ST_BAD;
        default:           state_r <= rvt_pkg::ST_IDLE;
      endcase
    end
  end

  // first event of a ring only arms the comparison
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      seen_r <= 1'b0;
    end else if (!active) begin
      seen_r <= 1'b0;
    end else if (TR_EVENT) begin
      seen_r <= 1'b1;
    end
  end

  // delay counts whole ticks from detection; saturates at the goal
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      dly_cnt_r <= '0;
    end else if (state_r != rvt_pkg::ST_WAIT) begin
      dly_cnt_r <= '0;
    end else if (tick && dly_cnt_r < dly_goal) begin
      dly_cnt_r <= dly_cnt_r + 1'b1;
    end
  end

  // outputs: bypass follows the detector when validation is off
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      RING_VALID   <= 1'b0;
      RING_INVALID <= 1'b0;
    end else begin
      RING_VALID   <= cfg.ring_validation_enable
                      ? (state_r == rvt_pkg::ST_VALID && RING_DET) : RING_DET;
      RING_INVALID <= cfg.ring_validation_enable && RING_DET && active
                      && TR_EVENT && too_fast;
    end
  end

  // sticky too-fast flag, write one to clear; a new hit wins over the clear
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ferr_r <= 1'b0;
    end else if (active && TR_EVENT && too_fast) begin
      ferr_r <= 1'b1;
    end else if (wr_fire && wstrb0_r && wsel == rvt_pkg::SEL_STATUS
                 && wdata_r[rvt_pkg::STAT_FERR_POS]) begin
      ferr_r <= 1'b0;
    end
  end

  assign stat.valid    = RING_VALID;
  assign stat.freq_err = ferr_r;
  assign stat.timer    = timer;

endmodule : rvt_top

// ===== testbench/rvt_checker.sv
// checker for the ring validation timer, watching top-level ports only
// assumes one clock domain with the asynchronous active-low reset
`timescale 1ns/1ps
module rvt_checker (
  input wire logic        CLK_SYS,
  input wire logic        NRST,
  input wire logic        RING_DET,
  input wire logic        TR_EVENT,
  input wire logic        RING_VALID,
  input wire logic        RING_INVALID,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  // ************************************************
  // ring output properties
  // ************************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  // too-fast verdict is one pulse, caused by an event on a live ring
  a_invalid_pulse: assert property (RING_INVALID |=> !RING_INVALID)
    else $error("ring invalid pulse longer than one cycle");
  a_invalid_cause: assert property (RING_INVALID |-> $past(TR_EVENT) && $past(RING_DET))
    else $error("ring invalid without a preceding event");
  a_invalid_drops: assert property (RING_INVALID |=> !RING_VALID [*2])
    else $error("valid ring kept after invalidation");
  // valid never outlives the detector, in both modes
  a_valid_follows: assert property (!RING_DET |=> !RING_VALID)
    else $error("valid ring without detector");
  a_valid_cause: assert property ($rose(RING_VALID) |-> $past(RING_DET))
    else $error("valid ring rose without detector");

  // ************************************************
  // register bus properties
  // ************************************************
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
                                 |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before ready");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
                                 |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data changed before ready");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken while data pending");
  a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");

  c_invalid: cover property (RING_INVALID);
  c_valid_rise: cover property ($rose(RING_VALID));
  c_decerr: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h3);
endmodule : rvt_checker

bind rvt_top rvt_checker u_chk (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .RING_DET(RING_DET), .TR_EVENT(TR_EVENT),
  .RING_VALID(RING_VALID), .RING_INVALID(RING_INVALID), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
);

// ===== testbench/rvt_ring_model.sv
// ring detector front end: detector level and tip/ring event pulses
// assumes the bench calls its tasks; lines change just after a rising edge
`timescale 1ns/1ps
module rvt_ring_model (
  input  wire logic clk,
  output logic      ring_det,
  output logic      tr_event
);
  // ************************************************
  // line drivers
  // ************************************************
  int unsigned cyc = 0;
  int unsigned t0  = 0;

  // both lines are driven levels, never released
  initial begin
    ring_det = 1'h0;
    tr_event = 1'h0;
  end

  // edge count, read before update so t0 and monitor agree
  always @(posedge clk) cyc <= cyc + 1;

  task automatic ring_on();
    @(posedge clk);
    ring_det <= 1'h1;
    t0 = cyc;
  endtask : ring_on

  task automatic ring_off();
    @(posedge clk);
    ring_det <= 1'h0;
  endtask : ring_off

  // one-cycle event after gap edges
  task automatic ev(input int gap);
    repeat (gap) @(posedge clk);
    tr_event <= 1'h1;
    @(posedge clk);
    tr_event <= 1'h0;
  endtask : ev
endmodule : rvt_ring_model

// ===== testbench/tb_ring_validation_timing.sv
// self-checking bench for the ring validation timer
// assumes the checker is bound in and the front end model drives the ring lines
`timescale 1ns/1ps
module tb_ring_validation_timing;
  // ************************************************
  // setup
  // ************************************************
  localparam int TK = 8;
  localparam int ST = 2;
  localparam logic [7:0] A_C1 = 8'(4 * rvt_pkg::REG_CTRL1_IDX);
  localparam logic [7:0] A_C2 = 8'(4 * rvt_pkg::REG_CTRL2_IDX);
  localparam logic [7:0] A_C3 = 8'(4 * rvt_pkg::REG_CTRL3_IDX);
  localparam logic [7:0] A_ST = 8'(4 * rvt_pkg::REG_STATUS_IDX);
  logic        clk_sys = 1'h0;
  logic        nrst    = 1'h0;
  logic [7:0]  awaddr  = 8'h0;
  logic [7:0]  araddr  = 8'h0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'h0;
  logic        wvalid  = 1'h0;
  logic        bready  = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready  = 1'h0;
  logic        rv_d    = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        ring_det, tr_event, ring_valid, ring_invalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [35:0] exp_q[$];
  int          mismatches = 0;
  int          compares   = 0;
  string       nm[3] = '{"bus_response", "valid_delay", "ring_invalid"};

  always #4 clk_sys = ~clk_sys;

  rvt_ring_model m (.clk(clk_sys), .ring_det(ring_det), .tr_event(tr_event));

  rvt_top #(.TICK_CYCLES(TK), .STEP_TICKS(ST)) dut (
    .CLK_SYS(clk_sys), .NRST(nrst), .RING_DET(ring_det), .TR_EVENT(tr_event),
    .RING_VALID(ring_valid), .RING_INVALID(ring_invalid),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
  );

  // ************************************************
  // checking
  // ************************************************
  // delay results carry a window since the tick phase is free-running
  task automatic chk(input logic [35:0] got);
    logic [35:0] e;
    logic        ok;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 36'hF_FFFF_FFFF;
    compares++;
    if (got[35:34] === 2'h1 && e[35:34] === 2'h1)
      ok = (got[15:0] >= e[31:16]) && (got[15:0] <= e[15:0]);
    else
      ok = (got === e);
    if (!ok) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm[got[35:34]], e, got);
    end
  endtask : chk

  // each result as it appears takes the oldest note
  always @(posedge clk_sys) begin
    rv_d <= ring_valid;
    if (rvalid && rready) chk({2'h0, rresp, rdata});
    if (bvalid && bready) chk({2'h0, bresp, 32'h0});
    if (ring_invalid === 1'h1) chk({2'h2, 34'h0});
    if (ring_valid && !rv_d) chk({2'h1, 2'h0, 32'(m.cyc - m.t0)});
  end

  task automatic print_verdict();
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // ************************************************
  // bus master, stalls ready one cycle to test holding
  // ************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    exp_q.push_back({2'h0, r, 32'h0});
    @(posedge clk_sys);
    awaddr  <= a;
    awvalid <= 1'h1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clk_sys);
    bready <= 1'h1;
    @(posedge clk_sys);
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    exp_q.push_back({2'h0, r, d});
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'h1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge clk_sys);
    rready <= 1'h1;
    @(posedge clk_sys);
    rready <= 1'h0;
  endtask : rd

  // upper data bits random: the design must ignore them
  task automatic cfg(input logic [2:0] code, input logic [5:0] mx, input logic en);
    logic [31:0] r;
    r = $urandom();
    wr(A_C1, {r[31:8], code[1:0], mx}, 4'hF, 2'h0);
    wr(A_C2, {r[31:8], code[2], r[6:0]}, 4'hF, 2'h0);
    wr(A_C3, {r[31:8], en, 7'h19}, 4'hF, 2'h0);
  endtask : cfg

  task automatic ring(input int lo, input int hi);
    exp_q.push_back({2'h1, 2'h0, 16'(lo), 16'(hi)});
    m.ring_on();
    while (exp_q.size() != 0) @(posedge clk_sys);
  endtask : ring

  // ************************************************
  // scenarios
  // ************************************************
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h75CB));
    repeat (10) @(posedge clk_sys);
    nrst <= 1'h1;
    rd(A_C1, 2'h0, 32'h96);
    rd(A_C2, 2'h0, 32'h0);
    rd(A_C3, 2'h0, 32'h19);
    rd(8'h80, 2'h3, 32'h0);
    wr(8'h80, 32'h1, 4'hF, 2'h3);
    wr(A_C1, {24'($urandom()), 8'h55}, 4'hF, 2'h0);
    wr(A_C1, 32'hAA, 4'h0, 2'h0);
    wr(A_C1 + 8'h1, 32'hAA, 4'hF, 2'h3);
    rd(A_C1, 2'h0, 32'h55);
    for (int c = 0; c < 8; c++) begin
      cfg(3'(c), 6'h0, 1'h1);
      ring(4 + c * ST * TK - (c > 0 ? TK : 0), 4 + c * ST * TK + 1);
      m.ring_off();
      repeat (5) @(posedge clk_sys);
    end
    // max 0x15 against start 0x19: four ticks of minimum spacing
    cfg(3'h0, 6'h15, 1'h1);
    ring(4, 4);
    exp_q.push_back({2'h2, 34'h0});
    m.ev(5);
    m.ev(8 * TK);
    m.ev(2 * TK);
    while (exp_q.size() != 0) @(posedge clk_sys);
    repeat (300) @(posedge clk_sys);
    rd(A_ST, 2'h0, 32'h2);
    wr(A_ST, 32'h2, 4'hF, 2'h0);
    m.ring_off();
    repeat (5) @(posedge clk_sys);
    // wide spacing must not wrap the timer past max 0
    cfg(3'h0, 6'h0, 1'h1);
    ring(4, 4);
    m.ev(5);
    m.ev(30 * TK);
    repeat (300) @(posedge clk_sys);
    rd(A_ST, 2'h0, 32'h1);
    m.ring_off();
    repeat (5) @(posedge clk_sys);
    // disabled: detector passes straight through, fast events ignored
    cfg(3'h0, 6'h15, 1'h0);
    ring(2, 2);
    m.ev(3);
    m.ev(TK);
    m.ev(TK);
    rd(A_C3, 2'h0, 32'h19);
    m.ring_off();
    print_verdict();
  end
endmodule : tb_ring_validation_timing
